// [bench/fes_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fes_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00a7, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0b3c  // arbitrary value
) (
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic [7:0]  busy_reads_i,
  output wire logic [15:0] dq_o,
  output var  logic        id_mode_o,
  output var  logic        busy_o,
  output var  logic [1:0]  kind_o,
  output var  logic [20:0] sect_o,
  output var  logic [7:0]  reads_o
);
  logic [2:0]  step;
  logic [7:0]  left;
  logic        tgl;
  logic [15:0] out;
  logic [11:0] a;
  logic [7:0]  d;
  // powers up in array read, never in id mode
  initial begin
    {step, left, tgl, out, id_mode_o, busy_o, kind_o, sect_o, reads_o} = '0;
  end
  // released bus shows the inverse of the last word, not a held value
  assign dq_o = (!ce_n_i && !oe_n_i) ? out : ~out;
  // ==========================================================
  // command decode: low byte and address bits 11..0 only
  always @(posedge we_n_i) begin
    a = addr_i[11:0];
    d = dq_i[7:0];
    if (!ce_n_i && !busy_o) begin
      case (step)
        3'd0, 3'd3: begin
          if (d == 8'hf0) id_mode_o = 1'b0;
          step = (a == 12'h555 && d == 8'haa) ? step + 3'd1 : 3'd0;
        end
        3'd1, 3'd4: step = (a == 12'h2aa && d == 8'h55) ? step + 3'd1 : 3'd0;
        3'd2: begin
          if (a == 12'h555 && d == 8'h90) id_mode_o = 1'b1;
          if (a == 12'h555 && d == 8'hf0) id_mode_o = 1'b0;
          step = (a == 12'h555 && d == 8'h80) ? 3'd3 : 3'd0;
        end
        default: begin
          if ((a == 12'h555 && d == 8'h10) || d == 8'h30) begin
            kind_o = (d == 8'h10) ? 2'd1 : 2'd2;
            sect_o = addr_i;
            busy_o = 1'b1;
            left = busy_reads_i;
            reads_o = 8'd0;
          end
          step = 3'd0;
        end
      endcase
    end
  end
  // ==========================================================
  // reads: toggling status while busy, id words or array data
  always @(negedge oe_n_i) begin
    if (!ce_n_i) begin
      out = addr_i[15:0] ^ 16'hc3a5;
      if (busy_o) begin
        tgl = ~tgl;
        out[6] = tgl;
        reads_o = reads_o + 8'd1;
        left = left - 8'd1;
        if (left == 8'd0) busy_o = 1'b0;
      end else if (id_mode_o) begin
        out = (addr_i[20:1] != 20'h0) ? 16'hbad0 : addr_i[0] ? PART_CODE : MAKER_CODE;
      end
    end
  end
endmodule // fes_flash_model
`default_nettype wire

// [bench/fes_host_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module fes_host_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        op_valid_i,
  input wire logic [1:0]  op_code_i,
  input wire logic [20:0] sect_addr_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [20:0] flash_addr_o,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe_o,
  input wire logic        flash_ce_n_o,
  input wire logic        flash_oe_n_o,
  input wire logic        flash_we_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // id mode tracker, so polling and id reads are told apart
  logic id_q;
  always @(posedge clk_i) begin
    if (rst_i) id_q <= 1'b0;
    else if (!flash_we_n_o && flash_dq_o[7:0] == 8'h90) id_q <= 1'b1;
    else if (!flash_we_n_o && flash_dq_o[7:0] == 8'hf0) id_q <= 1'b0;
  end
  sequence we_lo5; !flash_we_n_o [*5] ##1 flash_we_n_o; endsequence
  sequence oe_hi5; flash_oe_n_o [*5]; endsequence
  // ==========================================================
  // assertions
  idle_reset_a: assert property ($fell(rst_i) |-> flash_ce_n_o && flash_oe_n_o
    && flash_we_n_o && !flash_dq_oe_o && !busy_o && !done_o) else $error("not idle after reset");
  accept_op_a: assert property (!busy_o && !done_o && op_valid_i && op_code_i != 2'h3
    |=> busy_o) else $error("request not taken");
  refuse_op_a: assert property (!busy_o && op_valid_i && op_code_i == 2'h3 |=> !busy_o)
    else $error("code 3 taken");
  done_ends_a: assert property (done_o |-> !busy_o && $past(busy_o))
    else $error("done without busy");
  cmd_byte_a: assert property (!flash_we_n_o |-> flash_dq_oe_o && flash_dq_o[15:8] == 8'h00)
    else $error("bad command byte");
  cmd_addr_a: assert property (!flash_we_n_o && flash_dq_o[7:0] != 8'h30
    |-> flash_addr_o[20:12] == 9'h000) else $error("command address too wide");
  chip_addr_a: assert property (!flash_we_n_o && flash_dq_o[7:0] == 8'h10
    |-> flash_addr_o[11:0] == 12'h555) else $error("chip erase address");
  sect_addr_a: assert property (!flash_we_n_o && flash_dq_o[7:0] == 8'h30
    |-> flash_addr_o == sect_addr_i) else $error("sector erase address");
  poll_addr_a: assert property ($fell(flash_oe_n_o) && !id_q |-> flash_addr_o == sect_addr_i)
    else $error("polling address moved");
  id_addr_a: assert property ($fell(flash_oe_n_o) && id_q |-> flash_addr_o[20:1] == 20'h0)
    else $error("id read address");
  wr_pulse_a: assert property ($fell(flash_we_n_o) |-> we_lo5)
    else $error("write strobe width");
  oe_high_a: assert property ($rose(flash_oe_n_o) |-> oe_hi5)
    else $error("read strobe high pulse short");
  no_clash_a: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o)
    else $error("read and write overlap");
endmodule // fes_host_chk
`default_nettype wire

// [bench/fes_host_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module fes_host_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        op_valid_i = 1'b0;
  logic [1:0]  op_code_i = 2'h0;
  logic [20:0] sect_addr_i = 21'h0;
  logic        sect_small_i = 1'b0;
  logic        exit_long_i = 1'b0;
  logic [7:0]  busy_reads = 8'h01;
  wire logic        busy_o, done_o, timeout_o, dq_oe, ce_n, oe_n, we_n;
  wire logic [15:0] maker_id_o, part_id_o, dq_o, fl_dq;
  wire logic [20:0] addr_o;
  wire logic [15:0] dq_bus = dq_oe ? dq_o : fl_dq;
  int          fail_count = 0;
  int          checked = 0;
  int          seed = 52;
  int          rd_q[$];
  fes_host #(.SEC_SMALL_MAX_CYC(32'd300), .SEC_LARGE_MAX_CYC(32'd500)) fes_host_i (
    .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .sect_addr_i(sect_addr_i), .sect_small_i(sect_small_i), .exit_long_i(exit_long_i),
    .busy_o(busy_o), .done_o(done_o), .timeout_o(timeout_o), .maker_id_o(maker_id_o),
    .part_id_o(part_id_o), .flash_addr_o(addr_o), .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe),
    .flash_dq_i(dq_bus), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n));
  fes_flash_model fes_flash_model_i (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr_o), .dq_i(dq_bus),
    .busy_reads_i(busy_reads), .dq_o(fl_dq), .id_mode_o(), .busy_o(), .kind_o(),
    .sect_o(), .reads_o());
  initial forever #5 clk_i = ~clk_i;
  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // request held until busy shows, so a refused edge would be visible
  task automatic run_op(input logic [1:0] code);
    int n;
    @(negedge clk_i);
    op_code_i = code;
    op_valid_i = 1'b1;
    n = 0;
    while (busy_o !== 1'b1 && n < 20) begin @(negedge clk_i); n++; end
    op_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 5000) begin @(negedge clk_i); n++; end
    chk(done_o, 1'b1);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    int k;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    chk({ce_n, oe_n, we_n, dq_oe, busy_o, maker_id_o}, {4'b1110, 1'b0, 16'h0});
    for (k = 0; k < 2; k++) begin
      exit_long_i = k[0];
      run_op(2'h2);
      chk(maker_id_o, fes_flash_model_i.MAKER_CODE);
      chk(part_id_o, fes_flash_model_i.PART_CODE);
      chk(fes_flash_model_i.id_mode_o, 1'b0);
    end
    @(negedge clk_i);
    op_code_i = 2'h3;
    op_valid_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(busy_o, 1'b0);
    op_valid_i = 1'b0;
    // chip, small, large, small overrun, large overrun
    rd_q = '{0, 1, 0, 1, 0};
    for (k = 0; k < 5; k++) begin
      sect_addr_i = 21'($random(seed));
      sect_small_i = rd_q[k][0];
      busy_reads = (k > 2) ? 8'd60 : 8'(1 + ($random(seed) & 3));
      run_op(k == 0 ? 2'h0 : 2'h1);
      chk(fes_flash_model_i.kind_o, k == 0 ? 2'd1 : 2'd2);
      if (k > 0) chk(fes_flash_model_i.sect_o, sect_addr_i);
      chk(fes_flash_model_i.busy_o, 1'b0);
      chk(fes_flash_model_i.reads_o, busy_reads);
      chk(timeout_o, k > 2);
    end
    run_op(2'h2);
    chk(timeout_o, 1'b0);
    finish_test();
  end
  initial begin
    #(100000 * 10);
    fail_count++;
    finish_test();
  end
endmodule // fes_host_tb
bind fes_host fes_host_chk fes_host_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .sect_addr_i(sect_addr_i), .busy_o(busy_o), .done_o(done_o), .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o));
`default_nettype wire

// [design/fes_bus_cycle.v]
`timescale 1ns/100ps
`default_nettype none
`include "fes_defines.vh"

module fes_bus_cycle (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        wr_i,
  input  wire [20:0] addr_i,
  input  wire [15:0] wdata_i,
  output reg         done_o,
  output reg  [15:0] rdata_o,
  output reg  [20:0] flash_addr_o,
  output reg  [15:0] flash_dq_o,
  output reg         flash_dq_oe_o,
  input  wire [15:0] flash_dq_i,
  output reg         flash_ce_n_o,
  output reg         flash_oe_n_o,
  output reg         flash_we_n_o
);

  // ==========================================================
  // timing
  localparam integer TWP_N   = `FES_TWP_CYC - 1;
  localparam integer TWPH_N  = `FES_TWPH_CYC - 1;
  localparam integer TACC_N  = `FES_TACC_CYC + `FES_SYNC_CYC - 1;
  localparam integer READ_STROBE_HIGH_PULSE_N = `FES_READ_STROBE_HIGH_PULSE_CYC - 1;
  // counts are cut to the counter width on purpose, all fit in four bits
  localparam [3:0] TWP_C   = TWP_N[3:0];
  localparam [3:0] TWPH_C  = TWPH_N[3:0];
  localparam [3:0] TACC_C  = TACC_N[3:0];
  localparam [3:0] READ_STROBE_HIGH_PULSE_C = READ_STROBE_HIGH_PULSE_N[3:0];

  localparam [1:0] B_IDLE = 2'h0;
  localparam [1:0] B_SET  = 2'h1;
  localparam [1:0] B_PUL  = 2'h2;
  localparam [1:0] B_REC  = 2'h3;

  reg [1:0]  state_q;
  reg [3:0]  cnt_q;
  reg        wr_q;
  reg [15:0] dq_s1_q;
  reg [15:0] dq_s2_q;

  // ==========================================================
  // data pins come from outside, two flops before use
  always @(posedge clk_i) begin
    dq_s1_q <= flash_dq_i;
    dq_s2_q <= dq_s1_q;
  end

  // ==========================================================
  // one write or read cycle on the pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q       <= B_IDLE;
      cnt_q         <= 4'h0;
      wr_q          <= 1'b0;
      done_o        <= 1'b0;
      rdata_o       <= 16'h0000;
      flash_addr_o  <= 21'h000000;
      flash_dq_o    <= 16'h0000;
      flash_dq_oe_o <= 1'b0;
      flash_ce_n_o  <= 1'b1;
      flash_oe_n_o  <= 1'b1;
      flash_we_n_o  <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        B_IDLE: begin
          if (start_i) begin
            wr_q          <= wr_i;
            flash_addr_o  <= addr_i;
            flash_dq_o    <= wdata_i;
            flash_dq_oe_o <= wr_i;
            flash_ce_n_o  <= 1'b0;
            state_q       <= B_SET;
          end
        end
        B_SET: begin
          flash_we_n_o <= ~wr_q;
          flash_oe_n_o <= wr_q;
          // read wait covers access time plus the synchroniser
          cnt_q        <= wr_q ? TWP_C : TACC_C;
          state_q      <= B_PUL;
        end
        B_PUL: begin
          if (cnt_q == 4'h0) begin
            if (!wr_q) begin
              rdata_o <= dq_s2_q;
            end
            flash_we_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            // strobe high time also keeps data held after the write edge
            cnt_q        <= wr_q ? TWPH_C : READ_STROBE_HIGH_PULSE_C;
            state_q      <= B_REC;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        B_REC: begin
          if (cnt_q == 4'h0) begin
            flash_ce_n_o  <= 1'b1;
            flash_dq_oe_o <= 1'b0;
            done_o        <= 1'b1;
            state_q       <= B_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= B_IDLE;
        end
      endcase
    end
  end

endmodule // fes_bus_cycle

`default_nettype wire

// [design/fes_defines.vh]
`ifndef FES_DEFINES_VH
`define FES_DEFINES_VH

// ==========================================================
// clock
`define FES_CLK_NS        10
`define FES_CYC_PER_MS    (1000000 / `FES_CLK_NS)

// ==========================================================
// bus cycle times in ns, cycle counts round up (least times)
`define FES_TWP_NS        50
`define FES_TWPH_NS       35
`define FES_TACC_NS       85
`define FES_READ_STROBE_HIGH_PULSE_NS      50
`define FES_TWP_CYC       ((`FES_TWP_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_TWPH_CYC      ((`FES_TWPH_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_TACC_CYC      ((`FES_TACC_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_READ_STROBE_HIGH_PULSE_CYC     ((`FES_READ_STROBE_HIGH_PULSE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_SYNC_CYC      2

// ==========================================================
// erase times in ms (chip erase in s), limits round down (longest times)
`define FES_TSEC1_TYP_MS  60
`define FES_TSEC1_MAX_MS  90
`define FES_TSEC2_TYP_MS  200
`define FES_TSEC2_MAX_MS  300
`define FES_TEC_TYP_S     13
`define FES_TSEC1_MAX_CYC (`FES_TSEC1_MAX_MS * `FES_CYC_PER_MS)
`define FES_TSEC2_MAX_CYC (`FES_TSEC2_MAX_MS * `FES_CYC_PER_MS)

// ==========================================================
// command words: low byte data, 12-bit command address
`define FES_ADDR_UNLOCK1  12'h555
`define FES_ADDR_UNLOCK2  12'h2aa
`define FES_ADDR_ID0      21'h000000
`define FES_ADDR_ID1      21'h000001
`define FES_DAT_UNLOCK1   8'haa
`define FES_DAT_UNLOCK2   8'h55
`define FES_DAT_ERASE     8'h80
`define FES_DAT_CHIP      8'h10
`define FES_DAT_SECTOR    8'h30
`define FES_DAT_ID_ENTRY  8'h90
`define FES_DAT_ID_EXIT   8'hf0
`define FES_TOGGLE_BIT    6

// ==========================================================
// user operation codes
`define FES_OP_CHIP       2'h0
`define FES_OP_SECTOR     2'h1
`define FES_OP_ID         2'h2

// command sequence selectors
`define FES_SEQ_CHIP      3'h0
`define FES_SEQ_SECTOR    3'h1
`define FES_SEQ_ID_IN     3'h2
`define FES_SEQ_EXIT_S    3'h3
`define FES_SEQ_EXIT_L    3'h4

`endif

// [design/fes_host.v]
// Contract
// [R1] chip erase ends with data 10h at command address 555
// [R2] sector erase ends with data 30h at an address inside the sector
// [R3] toggle bit alternates on successive status reads while the flash is busy
// [R4] status polling keeps one fixed address for every read
// [R5] in id mode bit zero low gives maker code, high gives part code
// [R6] id mode is lost at power-down; flash restarts in array read
// [R7] after the id exit sequence the flash returns to array read
// [R8] both id exit sequences are equally valid
// [R9] commands use low data byte and address bits eleven to zero only
// [R10] small sector erase typically 60 ms, at most 90 ms
// [R11] large sector erase typically 200 ms, at most 300 ms
// [R12] chip erase takes about 13 s; poll until completion
// [R13] when the operation ends the toggle bit stops and array data returns
// [R14] id reads hold address bits one to twenty low, bit zero selects
`timescale 1ns/100ps
`default_nettype none
`include "fes_defines.vh"

module fes_host #(
  parameter [31:0] SEC_SMALL_MAX_CYC = `FES_TSEC1_MAX_CYC,
  parameter [31:0] SEC_LARGE_MAX_CYC = `FES_TSEC2_MAX_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        op_valid_i,
  input  wire [1:0]  op_code_i,
  input  wire [20:0] sect_addr_i,
  input  wire        sect_small_i,
  input  wire        exit_long_i,
  output reg         busy_o,
  output reg         done_o,
  output reg         timeout_o,
  output reg  [15:0] maker_id_o,
  output reg  [15:0] part_id_o,
  output wire [20:0] flash_addr_o,
  output wire [15:0] flash_dq_o,
  output wire        flash_dq_oe_o,
  input  wire [15:0] flash_dq_i,
  output wire        flash_ce_n_o,
  output wire        flash_oe_n_o,
  output wire        flash_we_n_o
);

  // ==========================================================
  // states
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_CMD   = 3'h1;
  localparam [2:0] S_POLL  = 3'h2;
  localparam [2:0] S_ID_RD = 3'h3;
  localparam [2:0] S_EXIT  = 3'h4;
  localparam [2:0] S_FIN   = 3'h5;

  reg [2:0]  state_q;
  reg [2:0]  seq_q;
  reg [2:0]  step_q;
  reg [1:0]  op_q;
  reg [20:0] sect_q;
  reg        small_q;
  reg        exit_long_q;
  reg        wait_q;
  reg        first_q;
  reg        prev_tgl_q;
  reg        id_sel_q;
  reg [31:0] tmo_cnt_q;
  reg        start_q;
  reg        wr_q;
  reg [20:0] addr_q;
  reg [15:0] wdata_q;

  wire        cyc_done;
  wire [15:0] rdata;
  wire [31:0] tmo_lim;
  wire [19:0] cmd_w;

  // ==========================================================
  // command table: {address, data}
  function [19:0] cmd_word;
    input [2:0] seq;
    input [2:0] step;
    begin
      cmd_word = {`FES_ADDR_UNLOCK1, `FES_DAT_UNLOCK1};
      case (step)
        3'h1: cmd_word = {`FES_ADDR_UNLOCK2, `FES_DAT_UNLOCK2};
        3'h2: begin
          if (seq == `FES_SEQ_ID_IN) begin
            cmd_word = {`FES_ADDR_UNLOCK1, `FES_DAT_ID_ENTRY};
          end else if (seq == `FES_SEQ_EXIT_L) begin
            cmd_word = {`FES_ADDR_UNLOCK1, `FES_DAT_ID_EXIT};
          end else begin
            cmd_word = {`FES_ADDR_UNLOCK1, `FES_DAT_ERASE};
          end
        end
        3'h4: cmd_word = {`FES_ADDR_UNLOCK2, `FES_DAT_UNLOCK2};
        3'h5: cmd_word = {`FES_ADDR_UNLOCK1, `FES_DAT_CHIP};         // [R1]
        default: cmd_word = {`FES_ADDR_UNLOCK1, `FES_DAT_UNLOCK1};
      endcase
      if (seq == `FES_SEQ_EXIT_S) begin
        cmd_word = {12'h000, `FES_DAT_ID_EXIT};
      end
    end
  endfunction

  function [2:0] cmd_last;
    input [2:0] seq;
    begin
      case (seq)
        `FES_SEQ_CHIP:   cmd_last = 3'h5;
        `FES_SEQ_SECTOR: cmd_last = 3'h5;
        `FES_SEQ_EXIT_S: cmd_last = 3'h0;
        default:         cmd_last = 3'h2;
      endcase
    end
  endfunction

  // a function result cannot be sliced, so the word is held on a net
  assign cmd_w = cmd_word(seq_q, step_q);

  // chip erase has no upper bound, so its limit trips only once the counter saturates at 32'hffffffff
  assign tmo_lim = (op_q != `FES_OP_SECTOR) ? 32'hffffffff :
                   (small_q ? SEC_SMALL_MAX_CYC : SEC_LARGE_MAX_CYC);   // [R10] [R11] [R12]

  // ==========================================================
  // sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= S_IDLE;
      seq_q       <= `FES_SEQ_CHIP;
      step_q      <= 3'h0;
      op_q        <= `FES_OP_CHIP;
      sect_q      <= 21'h000000;
      small_q     <= 1'b0;
      exit_long_q <= 1'b0;
      wait_q      <= 1'b0;
      first_q     <= 1'b0;
      prev_tgl_q  <= 1'b0;
      id_sel_q    <= 1'b0;
      tmo_cnt_q   <= 32'h00000000;
      start_q     <= 1'b0;
      wr_q        <= 1'b0;
      addr_q      <= 21'h000000;
      wdata_q     <= 16'h0000;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      timeout_o   <= 1'b0;
      maker_id_o  <= 16'h0000;
      part_id_o   <= 16'h0000;
    end else begin
      start_q <= 1'b0;
      done_o  <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (op_valid_i && op_code_i <= `FES_OP_ID) begin
            op_q        <= op_code_i;
            sect_q      <= sect_addr_i;
            small_q     <= sect_small_i;
            exit_long_q <= exit_long_i;
            seq_q       <= (op_code_i == `FES_OP_ID) ? `FES_SEQ_ID_IN : {1'b0, op_code_i};
            step_q      <= 3'h0;
            wait_q      <= 1'b0;
            timeout_o   <= 1'b0;
            busy_o      <= 1'b1;
            state_q     <= S_CMD;
          end
        end
        S_CMD, S_EXIT: begin
          if (!wait_q) begin
            start_q <= 1'b1;
            wr_q    <= 1'b1;
            wait_q  <= 1'b1;
            // upper data byte stays low, and address bits above eleven too except on the 30h sector write
            addr_q  <= {9'h000, cmd_w[19:8]};                            // [R9]
            wdata_q <= {8'h00, cmd_w[7:0]};                              // [R9]
            if (seq_q == `FES_SEQ_SECTOR && step_q == 3'h5) begin
              addr_q  <= sect_q;                                         // [R2]
              wdata_q <= {8'h00, `FES_DAT_SECTOR};                       // [R2]
            end
          end else if (cyc_done) begin
            wait_q <= 1'b0;
            if (step_q != cmd_last(seq_q)) begin
              step_q <= step_q + 3'h1;
            end else if (state_q == S_EXIT) begin
              state_q <= S_FIN;                                          // [R7]
            end else if (seq_q == `FES_SEQ_ID_IN) begin
              id_sel_q <= 1'b0;
              state_q  <= S_ID_RD;
            end else begin
              first_q   <= 1'b1;
              tmo_cnt_q <= 32'h00000000;
              state_q   <= S_POLL;
            end
          end
        end
        S_POLL: begin
          if (tmo_cnt_q != 32'hffffffff) begin
            tmo_cnt_q <= tmo_cnt_q + 32'h1;
          end
          // flag an overrun but keep polling until the toggle stops
          if (tmo_cnt_q >= tmo_lim) begin
            timeout_o <= 1'b1;                                           // [R10] [R11]
          end
          if (!wait_q) begin
            start_q <= 1'b1;
            wr_q    <= 1'b0;
            wait_q  <= 1'b1;
            addr_q  <= sect_q;                                           // [R4]
          end else if (cyc_done) begin
            wait_q     <= 1'b0;
            first_q    <= 1'b0;
            prev_tgl_q <= rdata[`FES_TOGGLE_BIT];                        // [R3]
            // two reads in a row with an equal toggle bit mean the operation has ended
            if (!first_q && rdata[`FES_TOGGLE_BIT] == prev_tgl_q) begin
              state_q <= S_FIN;                                          // [R12] [R13]
            end
          end
        end
        S_ID_RD: begin
          if (!wait_q) begin
            start_q <= 1'b1;
            wr_q    <= 1'b0;
            wait_q  <= 1'b1;
            addr_q  <= id_sel_q ? `FES_ADDR_ID1 : `FES_ADDR_ID0;         // [R14]
          end else if (cyc_done) begin
            wait_q <= 1'b0;
            if (!id_sel_q) begin
              maker_id_o <= rdata;                                       // [R5]
              id_sel_q   <= 1'b1;
            end else begin
              part_id_o <= rdata;                                        // [R5]
              seq_q     <= exit_long_q ? `FES_SEQ_EXIT_L : `FES_SEQ_EXIT_S; // [R8]
              step_q    <= 3'h0;
              state_q   <= S_EXIT;
            end
          end
        end
        S_FIN: begin
          busy_o  <= 1'b0;
          done_o  <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin timing
  fes_bus_cycle u_cyc (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .start_i       (start_q),
    .wr_i          (wr_q),
    .addr_i        (addr_q),
    .wdata_i       (wdata_q),
    .done_o        (cyc_done),
    .rdata_o       (rdata),
    .flash_addr_o  (flash_addr_o),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o),
    .flash_dq_i    (flash_dq_i),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_oe_n_o  (flash_oe_n_o),
    .flash_we_n_o  (flash_we_n_o)
  );

endmodule // fes_host

`default_nettype wire
